// file: dv/brk_core_model.sv
// behavioural processor core facing the break unit
`timescale 1ns/1ps
module brk_core_model (
  // clock
  input  wire logic        clk_i,
  // core side
  output logic      [15:0] cpu_addr_o,
  output logic             fetch_o,
  output logic             last_o,
  output logic             rti_o,
  output logic             wait_o,
  output logic             stop_o,
  output logic             monitor_o,
  output logic             test_volt_o
);
  initial
  begin
    {cpu_addr_o, fetch_o, last_o, rti_o} = 19'h0;
    {wait_o, stop_o, monitor_o, test_volt_o} = 4'h0;
  end
  // one bus cycle, then the address moves on
  task automatic cycle(input logic [15:0] a, input logic f, input logic l);
    @(posedge clk_i);
    cpu_addr_o <= a;
    fetch_o    <= f;
    last_o     <= l;
    @(posedge clk_i);
    cpu_addr_o <= ~a;
    fetch_o    <= 1'b0;
    last_o     <= 1'b0;
  endtask
  // return, rewound into wait if w
  task automatic ret(input logic w);
    @(posedge clk_i);
    rti_o <= 1'b1;
    @(posedge clk_i);
    rti_o  <= 1'b0;
    wait_o <= w;
  endtask
  task automatic modes(input logic w, input logic s, input logic m,
                       input logic t);
    @(posedge clk_i);
    wait_o      <= w;
    stop_o      <= s;
    monitor_o   <= m;
    test_volt_o <= t;
  endtask
endmodule

// file: dv/brk_unit_chk.sv
// checker bound to the address breakpoint unit
`timescale 1ns/1ps
`include "brk_cfg.svh"
module brk_unit_chk #(
  parameter int ADDR_W = 18
) (
  // clock and bus
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  // core
  input wire logic [15:0]       cpu_addr_i,
  input wire logic              cpu_pc_fetch_i,
  input wire logic              cpu_last_cycle_i,
  input wire logic              return_from_interrupt_i,
  input wire logic              in_wait_i,
  input wire logic              in_stop_i,
  input wire logic              monitor_mode_i,
  input wire logic              test_voltage_i,
  // break side effects
  input wire logic              brk_req_o,
  input wire logic [15:0]       vector_addr_o,
  input wire logic              stop_wake_o,
  input wire logic              timer_halt_o,
  input wire logic              capture_inhibit_o,
  input wire logic              watchdog_disable_o
);
  // ---------------------------------------------------------------
  // shadow state
  // ---------------------------------------------------------------
  logic [15:0] addr_r;
  logic        en_r;
  logic        pend_r;
  logic        wr;
  logic        bnd;
  logic        trig;
  assign wr = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  assign bnd = cpu_last_cycle_i | in_wait_i | in_stop_i;
  // no trigger while pending or active
  assign trig = ~timer_halt_o & ~pend_r
    & ((en_r & cpu_pc_fetch_i & (cpu_addr_i == addr_r))
    | (wr & pwdata_i[6] & (paddr_i == {`BRK_IDX_CTRL_STAT, 2'b00})));
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      addr_r <= 16'h0000;
      en_r   <= 1'b0;
      pend_r <= 1'b0;
    end
    else
    begin
      if (wr && paddr_i == {`BRK_IDX_ADDR_HI, 2'b00})
        addr_r[15:8] <= pwdata_i[7:0];
      if (wr && paddr_i == {`BRK_IDX_ADDR_LO, 2'b00})
        addr_r[7:0] <= pwdata_i[7:0];
      if (wr && paddr_i == {`BRK_IDX_CTRL_STAT, 2'b00})
        en_r <= pwdata_i[7];
      pend_r <= trig | (pend_r & ~brk_req_o);
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_MATCH_NOW: assert property (trig && bnd |=> brk_req_o)
    else $error("no break on boundary trigger");
  AST_ONLY_CAUSED: assert property (brk_req_o |-> pend_r)
    else $error("uncaused break");
  AST_HOLD_MID: assert property (pend_r && !brk_req_o && !bnd |=> !brk_req_o)
    else $error("break inside instruction");
  AST_GO_BOUND: assert property (pend_r && !brk_req_o && bnd |=> brk_req_o)
    else $error("pending break missed boundary");
  AST_VECTOR: assert property (brk_req_o |-> vector_addr_o ==
    ($past(monitor_mode_i) ? `BRK_VEC_MONITOR : `BRK_VEC_NORMAL))
    else $error("wrong break vector");
  AST_HALT_START: assert property ($rose(timer_halt_o) |-> brk_req_o)
    else $error("halt without break start");
  AST_HALT_HOLD: assert property (timer_halt_o && !return_from_interrupt_i
    |=> timer_halt_o && capture_inhibit_o)
    else $error("halt dropped in break");
  AST_RTI_END: assert property (timer_halt_o && return_from_interrupt_i
    |=> !timer_halt_o && !capture_inhibit_o)
    else $error("break not ended by return");
  AST_WDOG: assert property ((timer_halt_o && test_voltage_i)[*4]
    |-> watchdog_disable_o)
    else $error("watchdog not disabled");
  AST_STOP_WAKE: assert property (brk_req_o || stop_wake_o |-> brk_req_o
    && (stop_wake_o == $past(in_stop_i)))
    else $error("bad stop wake");
endmodule

bind address_breakpoint_unit brk_unit_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .pslverr_o, .cpu_addr_i, .cpu_pc_fetch_i, .cpu_last_cycle_i,
  .return_from_interrupt_i, .in_wait_i, .in_stop_i, .monitor_mode_i,
  .test_voltage_i, .brk_req_o, .vector_addr_o, .stop_wake_o,
  .timer_halt_o, .capture_inhibit_o, .watchdog_disable_o
);

// file: dv/tb_top.sv
// self-checking bench for the address breakpoint unit
`timescale 1ns/1ps
`include "brk_cfg.svh"
module tb_top;
  import brk_pkg::*;
  logic        clk_i     = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [17:0] paddr_i   = 18'h0_0000;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o;
  logic [15:0] cpu_addr, vec;
  logic        fetch, last, return_from_interrupt, wt, stp, mon, tv;
  logic        brk_req, software_interrupt_opcode, wake, halt, cap, wdog, irq;
  reg_byte_t   opc;
  int          fail_count = 0;
  int          checks     = 0;
  int          brk_n      = 0;
  int          wake_n     = 0;

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    brk_n  <= brk_n + int'({brk_req, software_interrupt_opcode} === 2'b11);
    wake_n <= wake_n + int'(wake === 1'b1);
  end

  address_breakpoint_unit #(.ADDR_W(18), .SWI_OPCODE(8'h5a)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .cpu_addr_i(cpu_addr), .cpu_pc_fetch_i(fetch),
    .cpu_last_cycle_i(last), .return_from_interrupt_i(return_from_interrupt),
    .in_wait_i(wt), .in_stop_i(stp), .monitor_mode_i(mon),
    .test_voltage_i(tv), .brk_req_o(brk_req), .swi_inject_o(software_interrupt_opcode),
    .software_interrupt_opcode_o(opc), .vector_addr_o(vec),
    .stop_wake_o(wake), .timer_halt_o(halt), .capture_inhibit_o(cap),
    .watchdog_disable_o(wdog), .irq_o(irq));
  brk_core_model u_core (
    .clk_i(clk_i), .cpu_addr_o(cpu_addr), .fetch_o(fetch), .last_o(last),
    .rti_o(return_from_interrupt), .wait_o(wt), .stop_o(stp), .monitor_o(mon),
    .test_volt_o(tv));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input reg_idx_t i, input reg_byte_t d,
                      input logic err);
    int n;
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= {i, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 16);
    chk("pready", 32'h1, 32'(pready_o));
    chk("pslverr", 32'(err), 32'(pslverr_o));
    if (!w)
      chk("prdata", err ? 32'h0 : {24'h0, d}, prdata_o);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1)
      stop_test();
  endtask
  task automatic wr(input reg_idx_t i, input reg_byte_t d);
    xfer(1'b1, i, d, 1'b0);
  endtask
  task automatic rd(input reg_idx_t i, input reg_byte_t d);
    xfer(1'b0, i, d, 1'b0);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`BRK_IDX_WAIT_STAT, 8'h10);
    rd(`BRK_IDX_FLAG_CTRL, 8'h00);
    rd(`BRK_IDX_ADDR_HI, 8'h00);
    rd(`BRK_IDX_ADDR_LO, 8'h00);
    rd(`BRK_IDX_CTRL_STAT, 8'h00);
    xfer(1'b0, 16'hfe01, 8'h00, 1'b1);
    wr(`BRK_IDX_WAIT_STAT, 8'hed);
    rd(`BRK_IDX_WAIT_STAT, 8'h10);
    wr(`BRK_IDX_CTRL_STAT, 8'h3f);
    rd(`BRK_IDX_CTRL_STAT, 8'h00);
    wr(`BRK_IDX_FLAG_CTRL, 8'h7f);
    rd(`BRK_IDX_FLAG_CTRL, 8'h00);
    wr(`BRK_IDX_ADDR_HI, 8'h12);
    wr(`BRK_IDX_ADDR_LO, 8'h34);
    rd(`BRK_IDX_ADDR_HI, 8'h12);
    wr(`BRK_IDX_CTRL_STAT, 8'h80);
    rd(`BRK_IDX_CTRL_STAT, 8'h80);
    // data access, then a fetch off by one
    u_core.cycle(16'h1234, 1'b0, 1'b1);
    u_core.cycle(16'h1235, 1'b1, 1'b1);
    settle(2);
    chk("breaks", 32'h0, brk_n);
    u_core.cycle(16'h1234, 1'b1, 1'b1);
    settle(2);
    chk("breaks", 32'h1, brk_n);
    chk("halt", 32'h3, 32'({halt, cap}));
    chk("vector", 32'hfffc, 32'(vec));
    chk("opcode", 32'h5a, 32'(opc));
    chk("wdog", 32'h0, 32'(wdog));
    rd(`BRK_IDX_CTRL_STAT, 8'hc0);
    chk("irq", 32'h0, 32'(irq));
    wr(`BRK_IDX_IRQ_MASK, 8'h01);
    settle(2);
    chk("irq", 32'h1, 32'(irq));
    wr(`BRK_IDX_IRQ_STAT, 8'h01);
    settle(2);
    chk("irq", 32'h0, 32'(irq));
    // a second match during the break is dropped
    u_core.cycle(16'h1234, 1'b1, 1'b1);
    settle(2);
    chk("breaks", 32'h1, brk_n);
    wr(`BRK_IDX_CTRL_STAT, 8'h80);
    rd(`BRK_IDX_CTRL_STAT, 8'h80);
    u_core.ret(1'b0);
    settle(1);
    chk("halt", 32'h0, 32'(halt));
    // mid-instruction match, monitor vector
    u_core.modes(1'b0, 1'b0, 1'b1, 1'b1);
    u_core.cycle(16'h1234, 1'b1, 1'b0);
    settle(2);
    chk("breaks", 32'h1, brk_n);
    u_core.cycle(16'h0000, 1'b1, 1'b1);
    settle(2);
    chk("breaks", 32'h2, brk_n);
    chk("vector", 32'hfefc, 32'(vec));
    chk("wdog", 32'h1, 32'(wdog));
    wr(`BRK_IDX_CTRL_STAT, 8'h00);
    u_core.ret(1'b0);
    // software break out of wait, flag protection
    u_core.modes(1'b1, 1'b0, 1'b0, 1'b0);
    wr(`BRK_IDX_CTRL_STAT, 8'h40);
    settle(2);
    chk("breaks", 32'h3, brk_n);
    u_core.modes(1'b0, 1'b0, 1'b0, 1'b0);
    rd(`BRK_IDX_WAIT_STAT, 8'h12);
    wr(`BRK_IDX_WAIT_STAT, 8'h10);
    rd(`BRK_IDX_WAIT_STAT, 8'h12);
    wr(`BRK_IDX_FLAG_CTRL, 8'h80);
    wr(`BRK_IDX_WAIT_STAT, 8'h10);
    rd(`BRK_IDX_WAIT_STAT, 8'h10);
    wr(`BRK_IDX_CTRL_STAT, 8'h00);
    u_core.ret(1'b1);
    // software break out of stop
    u_core.modes(1'b0, 1'b1, 1'b0, 1'b0);
    wr(`BRK_IDX_CTRL_STAT, 8'h40);
    settle(2);
    chk("wake", 32'h1, wake_n);
    u_core.modes(1'b0, 1'b0, 1'b0, 1'b0);
    rd(`BRK_IDX_STOP_STAT, 8'h01);
    wr(`BRK_IDX_STOP_STAT, 8'h00);
    rd(`BRK_IDX_STOP_STAT, 8'h00);
    wr(`BRK_IDX_CTRL_STAT, 8'h00);
    u_core.ret(1'b0);
    stop_test();
  end
endmodule

// file: hdl/address_breakpoint_unit.sv
// address breakpoint unit: break registers, break sequencing, side effects
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "brk_cfg.svh"
module address_breakpoint_unit #(
  parameter int                 ADDR_W     = 18,
  // interrupt opcode value; arbitrary default, set by the integrator
  parameter brk_pkg::reg_byte_t SWI_OPCODE = 8'h00
) (
  // clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 ce_i,
  // apb
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [ADDR_W-1:0]    paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  // processor core
  input  wire logic [15:0]          cpu_addr_i,
  input  wire logic                 cpu_pc_fetch_i,
  input  wire logic                 cpu_last_cycle_i,
  input  wire logic                 return_from_interrupt_i,
  input  wire logic                 in_wait_i,
  input  wire logic                 in_stop_i,
  input  wire logic                 monitor_mode_i,
  // reset pin test level, asynchronous
  input  wire logic                 test_voltage_i,
  // toward the system integration unit
  output logic                      brk_req_o,
  output logic                      swi_inject_o,
  output brk_pkg::reg_byte_t        software_interrupt_opcode_o,
  output logic      [15:0]          vector_addr_o,
  output logic                      stop_wake_o,
  // toward timers and watchdog
  output logic                      timer_halt_o,
  output logic                      capture_inhibit_o,
  output logic                      watchdog_disable_o,
  // interrupt
  output logic                      irq_o
);
  import brk_pkg::*;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  brk_state_t             state_r;
  brk_state_t             state_nxt;
  logic                   break_match_enable_r;
  logic                   break_active_flag_r;
  logic                   break_wait_flag_r;
  logic                   stop_wait_break_flag_r;
  logic                   break_flag_clear_permit_r;
  reg_byte_t              breakpoint_addr_high_r;
  reg_byte_t              breakpoint_addr_low_r;
  logic [`BRK_IRQ_W-1:0]  irq_stat_r;
  logic [`BRK_IRQ_W-1:0]  irq_mask_r;
  logic                   tv_meta_r;
  logic                   tv_sync_r;

  logic                   match;
  logic                   sw_trig;
  logic                   trig;
  logic                   boundary;
  logic                   start;
  logic                   clear_ok;
  logic                   wr_wait_stat;
  logic                   wr_flag_ctrl;
  logic                   wr_addr_hi;
  logic                   wr_addr_lo;
  logic                   wr_ctrl_stat;
  logic                   wr_stop_stat;
  logic                   wr_irq_stat;
  logic                   wr_irq_mask;
  logic [`BRK_IRQ_W-1:0]  irq_event;

  brk_reg_if rw ();

  // ---------------------------------------------------------------------
  // bus port
  // ---------------------------------------------------------------------
  brk_apb_port #(
    .ADDR_W (ADDR_W)
  ) u_apb (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .rw        (rw.port)
  );

  // ---------------------------------------------------------------------
  // address comparison
  // ---------------------------------------------------------------------
  // enabled full compare on fetches
  brk_addr_match #(
    .AW (16)
  ) u_match (
    .cpu_addr_i (cpu_addr_i),
    .brk_addr_i ({breakpoint_addr_high_r, breakpoint_addr_low_r}),
    .pc_fetch_i (cpu_pc_fetch_i),
    .enable_i   (break_match_enable_r),
    .match_o    (match)
  );

  // ---------------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------------
  assign wr_wait_stat = rw.wr_en && (rw.idx == `BRK_IDX_WAIT_STAT);
  assign wr_flag_ctrl = rw.wr_en && (rw.idx == `BRK_IDX_FLAG_CTRL);
  assign wr_addr_hi   = rw.wr_en && (rw.idx == `BRK_IDX_ADDR_HI);
  assign wr_addr_lo   = rw.wr_en && (rw.idx == `BRK_IDX_ADDR_LO);
  assign wr_ctrl_stat = rw.wr_en && (rw.idx == `BRK_IDX_CTRL_STAT);
  assign wr_stop_stat = rw.wr_en && (rw.idx == `BRK_IDX_STOP_STAT);
  assign wr_irq_stat  = rw.wr_en && (rw.idx == `BRK_IDX_IRQ_STAT);
  assign wr_irq_mask  = rw.wr_en && (rw.idx == `BRK_IDX_IRQ_MASK);

  // ---------------------------------------------------------------------
  // break sequencing
  // ---------------------------------------------------------------------
  // a written one breaks like a match
  assign sw_trig  = wr_ctrl_stat && rw.wdata[`BRK_BIT_ACTIVE];
  // breaks do not nest
  assign trig     = (match || sw_trig) && (state_r == ST_IDLE);
  // wait or stop: no instruction in flight
  assign boundary = cpu_last_cycle_i || in_wait_i || in_stop_i;
  assign start    = (state_nxt == ST_ACTIVE) && (state_r != ST_ACTIVE);
  // wait and stop flag clears inside the break need the permit
  assign clear_ok = (state_r != ST_ACTIVE) || break_flag_clear_permit_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        // start now on a last cycle
        if (trig)
          state_nxt = boundary ? ST_ACTIVE : ST_PEND;
      end
      ST_PEND:
      begin
        if (boundary)
          state_nxt = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (return_from_interrupt_i)
          state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      state_r <= ST_IDLE;
    else if (ce_i)
      state_r <= state_nxt;
  end

  // ---------------------------------------------------------------------
  // test voltage synchroniser
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      tv_meta_r <= 1'b0;
      tv_sync_r <= 1'b0;
    end
    else if (ce_i)
    begin
      tv_meta_r <= test_voltage_i;
      tv_sync_r <= tv_meta_r;
    end
  end

  // ---------------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      break_match_enable_r      <= 1'b0;
      break_flag_clear_permit_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl_stat)
        break_match_enable_r <= rw.wdata[`BRK_BIT_ENABLE];
      // only the permit bit is stored
      if (wr_flag_ctrl)
        break_flag_clear_permit_r <= rw.wdata[`BRK_BIT_PERMIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      breakpoint_addr_high_r <= `BRK_RST_BYTE;
      breakpoint_addr_low_r  <= `BRK_RST_BYTE;
    end
    else if (ce_i)
    begin
      if (wr_addr_hi)
        breakpoint_addr_high_r <= rw.wdata;
      if (wr_addr_lo)
        breakpoint_addr_low_r <= rw.wdata;
    end
  end

  // ---------------------------------------------------------------------
  // status flags (a set in the clearing cycle wins)
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      break_active_flag_r <= 1'b0;
    else if (ce_i)
    begin
      // set on trigger, zero write clears
      if (trig)
        break_active_flag_r <= 1'b1;
      else if (wr_ctrl_stat && !rw.wdata[`BRK_BIT_ACTIVE])
        break_active_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      break_wait_flag_r <= 1'b0;
    else if (ce_i)
    begin
      if (start && in_wait_i)
        break_wait_flag_r <= 1'b1;
      else if (wr_wait_stat && !rw.wdata[`BRK_BIT_WAIT] && clear_ok)
        break_wait_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      stop_wait_break_flag_r <= 1'b0;
    else if (ce_i)
    begin
      if (start && in_stop_i)
        stop_wait_break_flag_r <= 1'b1;
      else if (wr_stop_stat && !rw.wdata[`BRK_BIT_STOP] && clear_ok)
        stop_wait_break_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------------
  assign irq_event[`BRK_IRQ_START] = start;
  assign irq_event[`BRK_IRQ_WAIT]  = start && in_wait_i;
  assign irq_event[`BRK_IRQ_STOP]  = start && in_stop_i;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      irq_stat_r <= `BRK_RST_IRQ;
      irq_mask_r <= `BRK_RST_IRQ;
      irq_o      <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_stat_r <= irq_event |
                    (irq_stat_r &
                     ~(wr_irq_stat ? rw.wdata[`BRK_IRQ_W-1:0] : `BRK_RST_IRQ));
      if (wr_irq_mask)
        irq_mask_r <= rw.wdata[`BRK_IRQ_W-1:0];
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------------
  // outputs toward core, timers and watchdog
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      brk_req_o                   <= 1'b0;
      swi_inject_o                <= 1'b0;
      software_interrupt_opcode_o <= `BRK_RST_BYTE;
      vector_addr_o               <= `BRK_RST_VEC;
      stop_wake_o                 <= 1'b0;
    end
    else if (ce_i)
    begin
      brk_req_o    <= start;
      swi_inject_o <= start;
      software_interrupt_opcode_o <= SWI_OPCODE;
      vector_addr_o <= monitor_mode_i ? `BRK_VEC_MONITOR : `BRK_VEC_NORMAL;
      stop_wake_o  <= start && in_stop_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      timer_halt_o       <= 1'b0;
      capture_inhibit_o  <= 1'b0;
      watchdog_disable_o <= 1'b0;
    end
    else if (ce_i)
    begin
      timer_halt_o       <= (state_nxt == ST_ACTIVE);
      capture_inhibit_o  <= (state_nxt == ST_ACTIVE);
      // watchdog off only with test level
      watchdog_disable_o <= (state_nxt == ST_ACTIVE) && tv_sync_r;
    end
  end

  // ---------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------
  always_comb
  begin
    rw.rdata = `BRK_RST_BYTE;
    rw.hit   = 1'b1;
    unique case (rw.idx)
      `BRK_IDX_WAIT_STAT:
      begin
        rw.rdata = `BRK_WAIT_STAT_FIXED;
        rw.rdata[`BRK_BIT_WAIT] = break_wait_flag_r;
      end
      `BRK_IDX_FLAG_CTRL:
        rw.rdata[`BRK_BIT_PERMIT] = break_flag_clear_permit_r;
      `BRK_IDX_ADDR_HI:
        rw.rdata = breakpoint_addr_high_r;
      `BRK_IDX_ADDR_LO:
        rw.rdata = breakpoint_addr_low_r;
      `BRK_IDX_CTRL_STAT:
      begin
        rw.rdata[`BRK_BIT_ENABLE] = break_match_enable_r;
        rw.rdata[`BRK_BIT_ACTIVE] = break_active_flag_r;
      end
      `BRK_IDX_STOP_STAT:
        rw.rdata[`BRK_BIT_STOP] = stop_wait_break_flag_r;
      `BRK_IDX_IRQ_STAT:
        rw.rdata[`BRK_IRQ_W-1:0] = irq_stat_r;
      `BRK_IDX_IRQ_MASK:
        rw.rdata[`BRK_IRQ_W-1:0] = irq_mask_r;
      default:
        rw.hit = 1'b0;
    endcase
  end
endmodule

// file: hdl/brk_addr_match.sv
// bitwise comparison of the fetch address against the break address
`timescale 1ns/1ps
module brk_addr_match #(
  parameter int AW = 16
) (
  // compare inputs
  input  wire logic [AW-1:0] cpu_addr_i,
  input  wire logic [AW-1:0] brk_addr_i,
  input  wire logic          pc_fetch_i,
  input  wire logic          enable_i,
  // result
  output logic               match_o
);
  logic [AW-1:0] eq;

  genvar g;
  generate
    for (g = 0; g < AW; g++)
    begin : g_bit
      assign eq[g] = ~(cpu_addr_i[g] ^ brk_addr_i[g]);
    end
  endgenerate

  // only program counter cycles may match
  assign match_o = enable_i & pc_fetch_i & (&eq);
endmodule

// file: hdl/brk_apb_port.sv
// apb slave: one wait state, error when unmapped
`timescale 1ns/1ps
`include "brk_cfg.svh"
module brk_apb_port #(
  parameter int ADDR_W = 18
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  // apb
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // register side
  brk_reg_if.port                rw
);
  import brk_pkg::*;

  // elaboration check: the map needs 18 address bits
  if (ADDR_W < 18)
  begin : g_addr_w_chk
    $error("ADDR_W too small for the register map");
  end

  logic access;
  logic aligned;

  assign access   = psel_i & penable_i;
  assign aligned  = (paddr_i[1:0] == 2'b00) && ((paddr_i >> 18) == '0);
  assign rw.idx   = paddr_i[17:2];
  assign rw.wdata = pwdata_i[7:0];
  // writes land on the completing edge only
  assign rw.wr_en = ce_i & access & pready_o & pwrite_i & aligned & rw.hit;

  // ---------------------------------------------------------------------
  // answer one cycle into the access phase
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= `BRK_RDATA_ZERO;
    end
    else if (ce_i)
    begin
      pready_o  <= access & ~pready_o;
      pslverr_o <= access & ~pready_o & ~(aligned & rw.hit);
      prdata_o  <= (access && !pready_o && !pwrite_i && aligned && rw.hit)
                   ? {24'h00_0000, rw.rdata} : `BRK_RDATA_ZERO;
    end
  end
endmodule

// file: hdl/brk_cfg.svh
// address breakpoint unit: register map, field positions and constants
`ifndef BRK_CFG_SVH
`define BRK_CFG_SVH

// ---------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------------
`define BRK_IDX_WAIT_STAT   16'hfe00
`define BRK_IDX_FLAG_CTRL   16'hfe03
`define BRK_IDX_ADDR_HI     16'hfe09
`define BRK_IDX_ADDR_LO     16'hfe0a
`define BRK_IDX_CTRL_STAT   16'hfe0b
`define BRK_IDX_STOP_STAT   16'hfe0c
`define BRK_IDX_IRQ_STAT    16'hfe0d
`define BRK_IDX_IRQ_MASK    16'hfe0e

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define BRK_BIT_ENABLE      7
`define BRK_BIT_ACTIVE      6
`define BRK_BIT_WAIT        1
`define BRK_BIT_PERMIT      7
`define BRK_BIT_STOP        0
`define BRK_BIT_FIXED_ONE   4
`define BRK_IRQ_START       0
`define BRK_IRQ_WAIT        1
`define BRK_IRQ_STOP        2
`define BRK_IRQ_W           3

// ---------------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------------
`define BRK_RST_BYTE        8'h00
`define BRK_RST_IRQ         3'h0
`define BRK_WAIT_STAT_FIXED 8'h10
`define BRK_VEC_NORMAL      16'hfffc
`define BRK_VEC_MONITOR     16'hfefc
`define BRK_RST_VEC         16'h0000
`define BRK_RDATA_ZERO      32'h0000_0000

`endif

// file: hdl/brk_pkg.sv
// address breakpoint unit: shared types
package brk_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_PEND   = 2'b01,
    ST_ACTIVE = 2'b10
  } brk_state_t;

  typedef logic [15:0] reg_idx_t;
  typedef logic [7:0]  reg_byte_t;
endpackage

// file: hdl/brk_reg_if.sv
// register access carrier between the bus port and the break core
`timescale 1ns/1ps
interface brk_reg_if;
  logic               wr_en;
  brk_pkg::reg_idx_t  idx;
  brk_pkg::reg_byte_t wdata;
  brk_pkg::reg_byte_t rdata;
  logic               hit;

  modport port
  (
    output wr_en,
    output idx,
    output wdata,
    input  rdata,
    input  hit
  );
  modport regs
  (
    input  wr_en,
    input  idx,
    input  wdata,
    output rdata,
    output hit
  );
endinterface
